// [rtl/pfcs_pkg.sv]
// Shared constants and types for the port 2 flow control select block
`default_nettype none
package pfcs_pkg;

  // ***************************************************
  // Bus geometry and register map
  // ***************************************************
  localparam int unsigned PFCS_ADDR_W = 12;
  localparam int unsigned PFCS_DATA_W = 32;
  localparam logic [11:0] PFCS_FLOW_SEL_OFS = 12'h1a4;

  // ***************************************************
  // Field positions within the flow select register
  // ***************************************************
  localparam int unsigned PFCS_BIT_OVERRIDE = 0;
  localparam int unsigned PFCS_BIT_TX_EN = 1;
  localparam int unsigned PFCS_BIT_RX_EN = 2;
  localparam int unsigned PFCS_BIT_LIVE_TX = 3;
  localparam int unsigned PFCS_BIT_LIVE_RX = 4;
  localparam int unsigned PFCS_BIT_LIVE_DUP = 5;
  localparam int unsigned PFCS_BIT_BP = 6;
  localparam int unsigned PFCS_USED_W = 7;

  // ***************************************************
  // Response codes and write channel states
  // ***************************************************
  localparam logic [1:0] PFCS_RESP_OKAY = 2'h0;
  localparam logic [1:0] PFCS_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PFCS_W_COLLECT = 2'b01,
    PFCS_W_RESP = 2'b10
  } pfcs_wst_t;

endpackage
`default_nettype wire

// [rtl/pfcs_axil_slave.sv]
// AXI4-Lite slave front end with a single mapped register word
`timescale 1ns/1ps
`default_nettype none
module pfcs_axil_slave
  import pfcs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [PFCS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [PFCS_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [PFCS_ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [PFCS_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic wr_req,
  output logic [PFCS_DATA_W-1:0] wr_data,
  output logic [3:0] wr_strb,
  output logic rd_req,
  input wire logic [PFCS_DATA_W-1:0] reg_value
);

  // ***************************************************
  // Write path
  // ***************************************************
  pfcs_wst_t wst_q, wst_d;
  logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic aw_hit_q, aw_hit_d, bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic [PFCS_DATA_W-1:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;

  // Address and data may arrive in either order
  assign s_axi_awready = (wst_q == PFCS_W_COLLECT) && !aw_hold_q;
  assign s_axi_wready = (wst_q == PFCS_W_COLLECT) && !w_hold_q;
  assign wr_req = (wst_q == PFCS_W_COLLECT) && aw_hold_q && w_hold_q && aw_hit_q;
  assign wr_data = wdata_q;
  assign wr_strb = wstrb_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // Next write state
  always_comb begin
    wst_d = wst_q;
    aw_hold_d = aw_hold_q;
    w_hold_d = w_hold_q;
    aw_hit_d = aw_hit_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    case (wst_q)
      PFCS_W_COLLECT: begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_hold_d = 1'b1;
          aw_hit_d = (s_axi_awaddr[PFCS_ADDR_W-1:2] == PFCS_FLOW_SEL_OFS[PFCS_ADDR_W-1:2]);
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_hold_d = 1'b1;
          wdata_d = s_axi_wdata;
          wstrb_d = s_axi_wstrb;
        end
        if (aw_hold_q && w_hold_q) begin
          aw_hold_d = 1'b0;
          w_hold_d = 1'b0;
          bvalid_d = 1'b1;
          bresp_d = aw_hit_q ? PFCS_RESP_OKAY : PFCS_RESP_SLVERR;
          wst_d = PFCS_W_RESP;
        end
      end
      PFCS_W_RESP: begin
        if (s_axi_bready) begin
          bvalid_d = 1'b0;
          wst_d = PFCS_W_COLLECT;
        end
      end
      default: wst_d = PFCS_W_COLLECT;
    endcase
  end

  // Write state registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_q <= PFCS_W_COLLECT;
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_hit_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= PFCS_RESP_OKAY;
    end else begin
      wst_q <= wst_d;
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      aw_hit_q <= aw_hit_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
    end
  end

  // ***************************************************
  // Read path
  // ***************************************************
  logic rvalid_q, rvalid_d, rd_hit;
  logic [1:0] rresp_q, rresp_d;
  logic [PFCS_DATA_W-1:0] rdata_q, rdata_d;

  assign s_axi_arready = !rvalid_q;
  assign rd_req = s_axi_arvalid && !rvalid_q;
  assign rd_hit = (s_axi_araddr[PFCS_ADDR_W-1:2] == PFCS_FLOW_SEL_OFS[PFCS_ADDR_W-1:2]);
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Unmapped reads return zero with an error
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (rd_req) begin
      rvalid_d = 1'b1;
      rdata_d = rd_hit ? reg_value : '0;
      rresp_d = rd_hit ? PFCS_RESP_OKAY : PFCS_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  // Read state registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= PFCS_RESP_OKAY;
    end else begin
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

endmodule
`default_nettype wire

// [rtl/pfcs_top.sv]
// Port 2 flow control select register with live flow control readback
//
// Contract
// R1 - Bit 6 enables half-duplex backpressure
// R2 - Bit 5 reads live duplex, 1 half
// R3 - Bit 4 reads live pause receive state
// R4 - Bit 3 reads live pause transmit state
// R5 - Bit 2 governs pause receive when selected
// R6 - Bit 1 governs pause transmit when selected
// R7 - Override clear, autoneg on: negotiated result rules
// R8 - Override clear, autoneg off: software bits rule
// R9 - Override set: software bits rule in full duplex
// R10 - Readback shows enables actually in force
// R11 - Writes never touch advertised pause capability
// R12 - Writable field defaults come from straps
// R13 - Status reset values combine several straps
// R14 - Strap reload updates the affected fields
// R15 - Bits 31 to 7 read zero
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module pfcs_top
  import pfcs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [PFCS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [PFCS_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [PFCS_ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [PFCS_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic backpressure_default_strap,
  input wire logic fullduplex_pause_default_strap,
  input wire logic flow_override_default_strap,
  input wire logic strap_reload,
  input wire logic autoneg_enable,
  input wire logic an_pause_receive,
  input wire logic an_pause_transmit,
  input wire logic port_half_duplex,
  output logic port_backpressure_enable,
  output logic pause_receive_active,
  output logic pause_transmit_active
);

  // ***************************************************
  // Bus front end
  // ***************************************************
  logic wr_req, rd_req;
  logic [PFCS_DATA_W-1:0] wr_data, reg_value;
  logic [3:0] wr_strb;

  pfcs_axil_slave u_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .wr_req(wr_req),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .rd_req(rd_req),
    .reg_value(reg_value)
  );

  // ***************************************************
  // Pause enable selection
  // ***************************************************
  // Returns {receive, transmit} actually in force.
  // Pause frames mean nothing in half duplex, so both drop there.
  function automatic logic [1:0] pick_pause(
    input logic ovr,
    input logic rx_sw,
    input logic tx_sw,
    input logic an_en,
    input logic an_rx,
    input logic an_tx,
    input logic half
  );
    logic [1:0] sel;
    sel = {rx_sw, tx_sw};
    if (half) begin
      sel = 2'b00;
    end else if (!ovr && an_en) begin
      sel = {an_rx, an_tx};
    end
    return sel;
  endfunction

  // ***************************************************
  // Writable control fields
  // ***************************************************
  logic bp_q, bp_d, rxen_q, rxen_d, txen_q, txen_d, ovr_q, ovr_d;
  logic sw_write;

  // Only byte lane 0 holds live fields; upper lanes are ignored
  assign sw_write = wr_req && wr_strb[0];

  // Next control values; loader wins over a same-cycle write
  always_comb begin
    bp_d = bp_q;
    rxen_d = rxen_q;
    txen_d = txen_q;
    ovr_d = ovr_q;
    if (!aresetn || strap_reload) begin
      // R12 strap defaults
      // R14 reload from loader
      bp_d = backpressure_default_strap;
      rxen_d = fullduplex_pause_default_strap;
      txen_d = fullduplex_pause_default_strap;
      ovr_d = flow_override_default_strap;
    end else if (sw_write) begin
      // R1 backpressure bit
      bp_d = wr_data[PFCS_BIT_BP];
      // R5 receive enable bit
      rxen_d = wr_data[PFCS_BIT_RX_EN];
      // R6 transmit enable bit
      txen_d = wr_data[PFCS_BIT_TX_EN];
      ovr_d = wr_data[PFCS_BIT_OVERRIDE];
    end
  end

  // Sampling straps under a synchronous reset keeps them registered
  always_ff @(posedge aclk) begin
    bp_q <= bp_d;
    rxen_q <= rxen_d;
    txen_q <= txen_d;
    ovr_q <= ovr_d;
  end

  // ***************************************************
  // Live status fields
  // ***************************************************
  logic dup_q, dup_d, lrx_q, lrx_d, ltx_q, ltx_d;
  logic [1:0] live_sel;

  // R7 negotiated result path
  // R8 software path with autoneg off
  // R9 override in full duplex
  // R13 reset status from strap mix
  always_comb begin
    if (!aresetn) begin
      live_sel = pick_pause(flow_override_default_strap,
        fullduplex_pause_default_strap, fullduplex_pause_default_strap,
        autoneg_enable, an_pause_receive, an_pause_transmit, port_half_duplex);
    end else begin
      live_sel = pick_pause(ovr_q, rxen_q, txen_q, autoneg_enable,
        an_pause_receive, an_pause_transmit, port_half_duplex);
    end
    dup_d = port_half_duplex;
    lrx_d = live_sel[1];
    ltx_d = live_sel[0];
  end

  // Pause status registers feed both the port and readback; duplex status feeds readback only
  always_ff @(posedge aclk) begin
    dup_q <= dup_d;
    lrx_q <= lrx_d;
    ltx_q <= ltx_d;
  end

  // ***************************************************
  // Outputs and readback
  // ***************************************************
  // R11 no path toward advertised capability
  // The PHY advertisement stays owned by the PHY; nothing here drives it.
  assign port_backpressure_enable = bp_q;
  assign pause_receive_active = lrx_q;
  assign pause_transmit_active = ltx_q;

  // R2 duplex readback
  // R3 receive state readback
  // R4 transmit state readback
  // R10 enables in force shown
  // R15 reserved bits zero
  assign reg_value = {{(PFCS_DATA_W - PFCS_USED_W){1'b0}}, bp_q, dup_q, lrx_q,
    ltx_q, rxen_q, txen_q, ovr_q};

  // ***************************************************
  // Checks
  // ***************************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_sw_write;
    sw_write && !strap_reload;
  endsequence

  sequence s_read_taken;
    rd_req ##1 s_axi_rvalid;
  endsequence

  // R1 write reaches backpressure output
  a_bp_write_out: assert property ( // R1
    s_sw_write |=> port_backpressure_enable == $past(wr_data[PFCS_BIT_BP]))
    else $error("backpressure enable not taken from write");

  // R5 write reaches receive enable
  a_rx_write: assert property ( // R5
    s_sw_write |=> rxen_q == $past(wr_data[PFCS_BIT_RX_EN]))
    else $error("receive enable not taken from write");

  // R6 write reaches transmit enable
  a_tx_write: assert property ( // R6
    s_sw_write |=> txen_q == $past(wr_data[PFCS_BIT_TX_EN]))
    else $error("transmit enable not taken from write");

  // R10 control fields and duplex status read back
  a_ctrl_readback: assert property ( // R10
    s_read_taken |-> (s_axi_rresp != PFCS_RESP_OKAY)
      || {s_axi_rdata[PFCS_BIT_BP],
        s_axi_rdata[PFCS_BIT_LIVE_DUP],
        s_axi_rdata[PFCS_BIT_RX_EN],
        s_axi_rdata[PFCS_BIT_TX_EN],
        s_axi_rdata[PFCS_BIT_OVERRIDE]}
        == $past({bp_q, dup_q, rxen_q, txen_q, ovr_q}))
    else $error("control fields readback wrong");

  // R2 duplex status register follows the port one cycle later
  a_dup_track: assert property ( // R2
    ##1 dup_q == $past(port_half_duplex))
    else $error("duplex status does not follow port");

  // R3 receive status readback
  a_rx_readback: assert property ( // R3
    s_read_taken |-> (s_axi_rresp != PFCS_RESP_OKAY)
      || s_axi_rdata[PFCS_BIT_LIVE_RX] == $past(lrx_q))
    else $error("receive status readback wrong");

  // R4 transmit status readback
  a_tx_readback: assert property ( // R4
    s_read_taken |-> (s_axi_rresp != PFCS_RESP_OKAY)
      || s_axi_rdata[PFCS_BIT_LIVE_TX] == $past(ltx_q))
    else $error("transmit status readback wrong");

  // R5 R6 pause off in half duplex
  a_half_no_pause: assert property ( // R5
    port_half_duplex |=> !pause_receive_active && !pause_transmit_active)
    else $error("pause active in half duplex");

  // R7 negotiated result governs
  a_an_governs: assert property ( // R7
    (!ovr_q && autoneg_enable && !port_half_duplex)
      |=> {pause_receive_active, pause_transmit_active}
        == {$past(an_pause_receive), $past(an_pause_transmit)})
    else $error("negotiated pause not applied");

  // R8 software bits with autoneg off
  a_sw_an_off: assert property ( // R8
    (!ovr_q && !autoneg_enable && !port_half_duplex)
      |=> {pause_receive_active, pause_transmit_active}
        == {$past(rxen_q), $past(txen_q)})
    else $error("software pause not applied with autoneg off");

  // R9 override governs in full duplex
  a_override_fd: assert property ( // R9
    (ovr_q && !port_half_duplex)
      |=> {pause_receive_active, pause_transmit_active}
        == {$past(rxen_q), $past(txen_q)})
    else $error("override pause not applied");

  // R12 strap defaults after reset
  a_strap_reset: assert property ( // R12
    $rose(aresetn) |-> {bp_q, ovr_q} == {$past(backpressure_default_strap),
      $past(flow_override_default_strap)} && rxen_q == txen_q)
    else $error("reset value does not match straps");

  // R14 reload updates fields
  a_strap_reload: assert property ( // R14
    strap_reload |=> {bp_q, rxen_q, txen_q, ovr_q}
      == {$past(backpressure_default_strap), {2{$past(fullduplex_pause_default_strap)}},
        $past(flow_override_default_strap)})
    else $error("loader values not applied");

  // R15 reserved bits read zero
  a_rsvd_zero: assert property ( // R15
    s_axi_rvalid |-> s_axi_rdata[PFCS_DATA_W-1:PFCS_USED_W] == '0)
    else $error("reserved bits not zero");

endmodule
`default_nettype wire

// [verification/pfcs_tb_top.sv]
// Self-checking bench for the port 2 flow control select register
`timescale 1ns/1ps
`default_nettype none
module pfcs_tb_top
  import pfcs_pkg::*;
;
  // ***************************************************
  // Signals and design instance
  // ***************************************************
  logic aclk, aresetn;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [PFCS_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [PFCS_DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic backpressure_default_strap, fullduplex_pause_default_strap;
  logic flow_override_default_strap, strap_reload, autoneg_enable;
  logic an_pause_receive, an_pause_transmit, port_half_duplex;
  logic port_backpressure_enable, pause_receive_active, pause_transmit_active;
  // Expected writable fields, tracked by the bench alone
  logic e_bp, e_rx, e_tx, e_ovr;
  logic [31:0] rd;
  logic [1:0] rsp;
  int mismatches, total_checks;

  pfcs_top dut (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .backpressure_default_strap, .fullduplex_pause_default_strap,
    .flow_override_default_strap, .strap_reload, .autoneg_enable,
    .an_pause_receive, .an_pause_transmit, .port_half_duplex,
    .port_backpressure_enable, .pause_receive_active, .pause_transmit_active
  );

  // 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ***************************************************
  // Compare tasks and expectations
  // ***************************************************
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t word got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t resp got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t pin got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Enable in force; pause exists only in full duplex, so half forces it off
  function automatic logic eff(input logic sw, input logic an);
    return !port_half_duplex && ((e_ovr || !autoneg_enable) ? sw : an);
  endfunction

  function automatic logic [31:0] exp_word();
    return {25'h0, e_bp, port_half_duplex, eff(e_rx, an_pause_receive),
            eff(e_tx, an_pause_transmit), e_rx, e_tx, e_ovr};
  endfunction

  // ***************************************************
  // Bus master tasks
  // ***************************************************
  // Address and data offered together, each released once taken
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
                           input logic [3:0] s, output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    logic ar_ok;
    ar_ok = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (!ar_ok && s_axi_arready) begin
        ar_ok = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask

  // Read the register back and compare it and the port pins
  task automatic check_state();
    axi_read(PFCS_FLOW_SEL_OFS, rd, rsp);
    chk_resp(rsp, PFCS_RESP_OKAY); // mapped read accepted
    chk_word(rd, exp_word()); // readback word
    chk_bit(port_backpressure_enable, e_bp); // backpressure pin
    chk_bit(pause_receive_active, eff(e_rx, an_pause_receive)); // receive pin
    chk_bit(pause_transmit_active, eff(e_tx, an_pause_transmit)); // transmit pin
  endtask

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog; the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge aclk);
    mismatches++;
    report_and_stop();
  end

  // ***************************************************
  // Test sequence
  // ***************************************************
  initial begin
    mismatches = 0;
    total_checks = 0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    s_axi_awaddr = 12'h0;
    s_axi_araddr = 12'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    {backpressure_default_strap, fullduplex_pause_default_strap} = 2'b11;
    flow_override_default_strap = 1'b0;
    strap_reload = 1'b0;
    autoneg_enable = 1'b1;
    an_pause_receive = 1'b1;
    an_pause_transmit = 1'b0;
    port_half_duplex = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    {e_bp, e_rx, e_tx, e_ovr} = 4'b1110;
    check_state(); // strap defaults after reset
    $display("test reset_defaults done");
    // Every mix of override, autoneg and duplex; reserved and status bits written as ones
    for (int i = 0; i < 16; i++) begin
      e_ovr = i[0];
      e_rx = i[3];
      e_tx = !i[3];
      e_bp = i[3] ^ i[0];
      autoneg_enable <= i[1];
      port_half_duplex <= i[2];
      an_pause_receive <= !i[3];
      an_pause_transmit <= i[3];
      axi_write(PFCS_FLOW_SEL_OFS, {25'h1ffffff, e_bp, 3'b111, e_rx, e_tx, e_ovr}, 4'hf, rsp);
      chk_resp(rsp, PFCS_RESP_OKAY); // write accepted
      check_state(); // mode selection
    end
    $display("test mode_table done");
    // Lane 0 disabled: accepted but nothing changes
    axi_write(PFCS_FLOW_SEL_OFS, 32'h0, 4'he, rsp);
    chk_resp(rsp, PFCS_RESP_OKAY); // partial write accepted
    check_state(); // fields unchanged
    $display("test strobe done");
    // Unmapped neighbours refused and harmless
    axi_write(12'h1a0, 32'h0, 4'hf, rsp);
    chk_resp(rsp, PFCS_RESP_SLVERR); // unmapped write refused
    check_state(); // register untouched
    axi_read(12'h1a8, rd, rsp);
    chk_resp(rsp, PFCS_RESP_SLVERR); // unmapped read refused
    chk_word(rd, 32'h0); // unmapped data zero
    $display("test unmapped done");
    // Loader rewrites straps in both directions
    for (int j = 0; j < 2; j++) begin
      backpressure_default_strap <= j[0];
      fullduplex_pause_default_strap <= j[0];
      flow_override_default_strap <= !j[0];
      @(posedge aclk);
      strap_reload <= 1'b1;
      @(posedge aclk);
      strap_reload <= 1'b0;
      {e_bp, e_rx, e_tx, e_ovr} = {j[0], j[0], j[0], !j[0]};
      check_state(); // reloaded fields
    end
    // Second reset with a different strap mix
    backpressure_default_strap <= 1'b0;
    flow_override_default_strap <= 1'b1;
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    {e_bp, e_rx, e_tx, e_ovr} = 4'b0111;
    check_state(); // defaults from new straps
    $display("test strap_reload done");
    report_and_stop();
  end
endmodule
`default_nettype wire
